// *** hw/lira_pkg.sv ***
// constants, register map and field layout of the legacy interrupt router
package lira_pkg;
    // ==========================================================
    // sizes
    localparam int NCORE      = 4;
    localparam int NOUT       = 8;
    localparam int NLINE      = 64;
    localparam int I2C_W      = 8;
    localparam int SPI_W      = 5;
    localparam int UART_W     = 5;
    localparam int AUXSER_W   = 3;
    localparam int NET_L2_W   = 57;
    localparam int NPAIR      = 4;
    localparam int TMR_PER_CORE  = 4;
    localparam int MBOX_PER_CORE = 4;
    localparam int NSOFT      = 8;
    localparam int NAUX_HW    = 8;

    // ==========================================================
    // shared peripheral line numbers
    localparam int PL_AUXSER  = 29;
    localparam int PL_I2C     = 53;
    localparam int PL_SPI     = 54;
    localparam int PL_UART    = 57;
    localparam int PL_NET     = 58;
    localparam int PL_NET_SEC = 63;
    localparam int PL_PAIR0   = 23;
    localparam int PL_PAIR1   = 24;
    localparam int PL_PAIR2   = 46;
    localparam int PL_PAIR3   = 62;

    // ==========================================================
    // summary register layout
    localparam int SUM_I2C_LSB  = 8;
    localparam int SUM_UART_LSB = 16;
    localparam int SUM_SPI_LSB  = 24;

    // ==========================================================
    // addresses
    localparam logic [31:0] SUMMARY_ADDR  = 32'h7e20_4e00;
    localparam logic [19:0] LOCAL_BASE_HI = 20'h7e20f;
    localparam logic [11:0] OFF_CTRL      = 12'h000;
    localparam logic [11:0] OFF_SOFT_SET  = 12'h004;
    localparam logic [11:0] OFF_SOFT_CLR  = 12'h008;
    localparam logic [11:0] OFF_PMU_SET   = 12'h00c;
    localparam logic [11:0] OFF_PMU_CLR   = 12'h010;
    localparam logic [11:0] OFF_LROUTE    = 12'h014;
    localparam logic [11:0] OFF_RAW0      = 12'h018;
    localparam logic [11:0] OFF_RAW1      = 12'h01c;
    localparam logic [11:0] OFF_RAW2      = 12'h020;
    localparam logic [7:0]  BLK_TIMER     = 8'h04;
    localparam logic [7:0]  BLK_MBOX      = 8'h05;
    localparam logic [3:0]  BLK_EN        = 4'h1;
    localparam logic [3:0]  BLK_STAT      = 4'h2;
    localparam logic [2:0]  EN_CLR_FIRST  = 3'h3;
    localparam logic [2:0]  EN_LAST       = 3'h5;
    localparam logic [1:0]  STAT_SOURCE   = 2'h3;

    // ==========================================================
    // control fields
    localparam int CTRL_LEGACY    = 0;
    localparam int CTRL_QUIET_EN  = 1;
    localparam int CTRL_BERR_EN   = 2;
    localparam int CTRL_BERR_DEST = 4;
    localparam int LR_EN          = 3;
    localparam int FIQ_SEL_LSB    = 4;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // ==========================================================
    // source and pending layout
    localparam int SRC_TIMER_LSB = 0;
    localparam int SRC_MBOX_LSB  = 4;
    localparam int SRC_PEND2     = 8;
    localparam int SRC_PMU       = 9;
    localparam int SRC_QUIET     = 10;
    localparam int SRC_LTIMER    = 11;
    localparam int SRC_BERR      = 12;
    localparam int P2_PEND0      = 24;
    localparam int P2_PEND1      = 25;
    localparam int QUIET_OUT     = 1;
endpackage

// *** hw/lira_comb_if.sv ***
// combined peripheral lines and summary status between combiner and router
`timescale 1ns/1ps
interface lira_comb_if;
    logic [63:0] lines;
    logic [31:0] summary;
    modport src (output lines, output summary);
    modport dst (input lines, input summary);
endinterface

// *** hw/lira_periph_comb.sv ***
// or-combining of shared peripheral lines and per-peripheral summary
`timescale 1ns/1ps
module lira_periph_comb
    import lira_pkg::*;
(
    // single-source lines and second sources
    input  wire logic [NLINE-1:0]    periph_i,
    input  wire logic [NPAIR-1:0]    pair_b_i,
    // grouped peripherals
    input  wire logic [AUXSER_W-1:0] auxser_i,
    input  wire logic [I2C_W-1:0]    i2c_i,
    input  wire logic [SPI_W-1:0]    spi_i,
    input  wire logic [UART_W-1:0]   uart_i,
    input  wire logic [NET_L2_W-1:0] net_l2_i,
    input  wire logic                net_secure_i,
    // combined view
    lira_comb_if.src                 bus
);
    // ==========================================================
    // combining, pure levels
    always_comb begin
        bus.lines             = periph_i;
        bus.lines[PL_AUXSER]  = |auxser_i;                             // see R3 R25
        bus.lines[PL_I2C]     = |i2c_i;                                // see R3
        bus.lines[PL_SPI]     = |spi_i;                                // see R3
        bus.lines[PL_UART]    = |uart_i;                               // see R3
        bus.lines[PL_NET]     = |net_l2_i;                             // see R7 R8 R9
        bus.lines[PL_NET_SEC] = net_secure_i;                          // see R8
        bus.lines[PL_PAIR0]   = periph_i[PL_PAIR0] | pair_b_i[0];      // see R6
        bus.lines[PL_PAIR1]   = periph_i[PL_PAIR1] | pair_b_i[1];      // see R6
        bus.lines[PL_PAIR2]   = periph_i[PL_PAIR2] | pair_b_i[2];      // see R6
        bus.lines[PL_PAIR3]   = periph_i[PL_PAIR3] | pair_b_i[3];      // see R6
        bus.summary           = 32'h0000_0000;
        bus.summary[SUM_I2C_LSB +: I2C_W] = i2c_i;                     // see R4 R25
        // fifth uart sits at summary bit 17, the second bit of the uart field
        bus.summary[SUM_UART_LSB +: UART_W] = {uart_i[3], uart_i[2], uart_i[1], uart_i[4], uart_i[0]}; // see R5
        bus.summary[SUM_SPI_LSB +: SPI_W] = spi_i;
    end
endmodule // lira_periph_comb

// *** hw/lira_router.sv ***
// legacy interrupt routing and aggregation with wishbone register slave
// Contract
// R1: aux inputs: timer, mailbox, doorbells, halts, errors, soft
// R2: eight soft flags via set and clear
// R3: lines 29,53,54,57 are OR of groups
// R4: i2c statuses in summary bits 15:8
// R5: uart statuses in summary 20:16, fifth at 17
// R6: lines 23,24,46,62 OR two sources
// R7: network group numbering; others reserved
// R8: network group ORed to 58, secure 63
// R9: only combined line 58 reaches router
// R10: selector picks generic or legacy outputs
// R11: legacy outputs always offered to generic controller
// R12: core timers, monitor route to own core
// R13: mailbox n to core n/4 only
// R14: bus-quiet only to core 0 irq
// R15: local timer, bus error to any output
// R16: cache raises bus error on error response
// R17: three raw status registers show unmasked inputs
// R18: per-output set and clear enable masks
// R19: per output three pending, one source
// R20: source bit 8, routed_pending_2 bit 24 nest
// R21: routed_pending_2 bit 25 nests routed_pending_1; 57 there
// R22: eight outputs, fiq and irq per core
// R23: write-set: ones set, zeros keep
// R24: write-clear: ones clear, zeros keep
// R25: combined lines follow source levels, unlatched
`timescale 1ns/1ps
module lira_router
    import lira_pkg::*;
(
    // clock and reset
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    // wishbone slave
    input  wire logic                          cyc_i,
    input  wire logic                          stb_i,
    input  wire logic                          we_i,
    input  wire logic [31:0]                   adr_i,
    input  wire logic [3:0]                    sel_i,
    input  wire logic [31:0]                   dat_i,
    output logic      [31:0]                   dat_o,
    output logic                               ack_o,
    // per-core sources
    input  wire logic [lira_pkg::NCORE*lira_pkg::TMR_PER_CORE-1:0]  core_timer_i,
    input  wire logic [lira_pkg::NCORE-1:0]                         perfmon_i,
    input  wire logic [lira_pkg::NCORE*lira_pkg::MBOX_PER_CORE-1:0] mailbox_i,
    // local sources
    input  wire logic                          local_timer_i,
    input  wire logic                          bus_error_irq_i,
    input  wire logic                          bus_quiet_i,
    // aux block hardware sources, bits 0..7
    input  wire logic [lira_pkg::NAUX_HW-1:0]  aux_block_i,
    // shared peripheral sources
    input  wire logic [lira_pkg::NLINE-1:0]    periph_i,
    input  wire logic [lira_pkg::NPAIR-1:0]    pair_b_i,
    input  wire logic [lira_pkg::AUXSER_W-1:0] auxser_i,
    input  wire logic [lira_pkg::I2C_W-1:0]    i2c_i,
    input  wire logic [lira_pkg::SPI_W-1:0]    spi_i,
    input  wire logic [lira_pkg::UART_W-1:0]   uart_i,
    input  wire logic [lira_pkg::NET_L2_W-1:0] net_l2_i,
    input  wire logic                          net_secure_i,
    // generic controller outputs
    input  wire logic [lira_pkg::NCORE-1:0]    gic_fiq_i,
    input  wire logic [lira_pkg::NCORE-1:0]    gic_irq_i,
    // to cores and generic controller
    output logic      [lira_pkg::NCORE-1:0]    core_fiq_o,
    output logic      [lira_pkg::NCORE-1:0]    core_irq_o,
    output logic      [lira_pkg::NOUT-1:0]     private_periph_input_o
);
    import lira_pkg::*;

    // ==========================================================
    // state
    logic [7:0]             ctrl_reg;
    logic [NSOFT-1:0]       soft_reg;
    logic [7:0]             pmu_reg;
    logic [3:0]             lroute_reg;
    logic [7:0]             timer_ctrl_reg [NCORE];
    logic [7:0]             mbox_ctrl_reg  [NCORE];
    logic [31:0]            en_reg         [NOUT][3];
    logic                   ack_reg;
    logic [31:0]            dat_reg;
    logic [NCORE-1:0]       fiq_reg;
    logic [NCORE-1:0]       irq_reg;
    logic [NOUT-1:0]        ppi_reg;

    lira_comb_if cb ();

    lira_periph_comb u_comb (
        .periph_i     (periph_i),
        .pair_b_i     (pair_b_i),
        .auxser_i     (auxser_i),
        .i2c_i        (i2c_i),
        .spi_i        (spi_i),
        .uart_i       (uart_i),
        .net_l2_i     (net_l2_i),
        .net_secure_i (net_secure_i),
        .bus          (cb.src)
    );

    // ==========================================================
    // raw inputs of the routing stage
    logic [15:0]      aux_w;
    logic [31:0]      raw_w   [3];
    logic [31:0]      stat_w  [NOUT][4];
    logic [NOUT-1:0]  leg_next;

    assign aux_w    = {soft_reg, aux_block_i};                       // see R1 R2
    assign raw_w[0] = cb.lines[31:0];                                // see R17
    assign raw_w[1] = cb.lines[63:32];                               // see R17 R9
    assign raw_w[2] = {16'h0000, aux_w};                             // see R17

    // ==========================================================
    // per-output masking and routing
    for (genvar o = 0; o < NOUT; o++) begin : g_out
        localparam int C      = o / 2;
        localparam bit IS_IRQ = (o % 2) == 1;
        logic [3:0]  tmr_en;
        logic [3:0]  tmr_fiq;
        logic [3:0]  mb_en;
        logic [3:0]  mb_fiq;
        logic [3:0]  tmr_hit;
        logic [3:0]  mb_hit;
        logic        pmu_hit;
        logic        quiet_hit;
        logic        lt_hit;
        logic        be_hit;
        logic [31:0] p2;
        logic [31:0] src;

        assign tmr_en  = timer_ctrl_reg[C][3:0];
        assign tmr_fiq = timer_ctrl_reg[C][FIQ_SEL_LSB +: 4];
        assign mb_en   = mbox_ctrl_reg[C][3:0];
        assign mb_fiq  = mbox_ctrl_reg[C][FIQ_SEL_LSB +: 4];
        // only this core's sources can reach this core's pair
        assign tmr_hit = core_timer_i[C*TMR_PER_CORE +: TMR_PER_CORE] & tmr_en
                       & (IS_IRQ ? ~tmr_fiq : tmr_fiq);              // see R12
        assign mb_hit  = mailbox_i[C*MBOX_PER_CORE +: MBOX_PER_CORE] & mb_en
                       & (IS_IRQ ? ~mb_fiq : mb_fiq);                // see R13
        assign pmu_hit = perfmon_i[C] & pmu_reg[C]
                       & (IS_IRQ ? ~pmu_reg[FIQ_SEL_LSB + C] : pmu_reg[FIQ_SEL_LSB + C]); // see R12
        assign quiet_hit = (o == QUIET_OUT) && ctrl_reg[CTRL_QUIET_EN] && bus_quiet_i; // see R14
        assign lt_hit  = lroute_reg[LR_EN] && local_timer_i
                       && (lroute_reg[2:0] == 3'(o));                // see R15
        // bus error is level-driven by the cache controller
        assign be_hit  = ctrl_reg[CTRL_BERR_EN] && bus_error_irq_i
                       && (ctrl_reg[CTRL_BERR_DEST +: 3] == 3'(o));  // see R15 R16

        assign stat_w[o][0] = raw_w[0] & en_reg[o][0];               // see R19
        assign stat_w[o][1] = raw_w[1] & en_reg[o][1];               // see R19 R21
        always_comb begin
            p2           = raw_w[2] & en_reg[o][2];
            p2[P2_PEND0] = |stat_w[o][0];                            // see R20
            p2[P2_PEND1] = |stat_w[o][1];                            // see R21
            src                            = 32'h0000_0000;
            src[SRC_TIMER_LSB +: 4]        = tmr_hit;
            src[SRC_MBOX_LSB +: 4]         = mb_hit;
            src[SRC_PEND2]                 = |p2;                    // see R20
            src[SRC_PMU]                   = pmu_hit;
            src[SRC_QUIET]                 = quiet_hit;
            src[SRC_LTIMER]                = lt_hit;
            src[SRC_BERR]                  = be_hit;
        end
        assign stat_w[o][2]           = p2;
        assign stat_w[o][STAT_SOURCE] = src;
        assign leg_next[o]            = |src;                        // see R22
    end

    // ==========================================================
    // output stage, all registered
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fiq_reg <= '0;
            irq_reg <= '0;
            ppi_reg <= '0;
        end else begin
            ppi_reg <= leg_next;                                     // see R11
            for (int c = 0; c < NCORE; c++) begin
                fiq_reg[c] <= ctrl_reg[CTRL_LEGACY] ? leg_next[2*c]   : gic_fiq_i[c]; // see R10
                irq_reg[c] <= ctrl_reg[CTRL_LEGACY] ? leg_next[2*c+1] : gic_irq_i[c]; // see R10
            end
        end
    end

    assign core_fiq_o             = fiq_reg;
    assign core_irq_o             = irq_reg;
    assign private_periph_input_o = ppi_reg;

    // ==========================================================
    // bus decode
    logic [31:0] bmask;
    logic [31:0] wbits;
    logic        req;
    logic        hit_local;
    logic [11:0] off;
    logic        is_en;
    logic [2:0]  en_out;
    logic [2:0]  en_k;
    logic        is_stat;
    logic [2:0]  st_out;
    logic [1:0]  st_k;
    logic [1:0]  en_idx;

    assign req       = cyc_i && stb_i && !ack_reg;
    assign bmask     = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
    assign wbits     = dat_i & bmask;
    assign hit_local = adr_i[31:12] == LOCAL_BASE_HI;
    assign off       = adr_i[11:0];
    assign is_en     = hit_local && off[11:8] == BLK_EN && off[4:2] <= EN_LAST;
    assign en_out    = off[7:5];
    assign en_k      = off[4:2];
    assign en_idx    = (en_k >= EN_CLR_FIRST) ? 2'(en_k - EN_CLR_FIRST) : en_k[1:0];
    assign is_stat   = hit_local && off[11:8] == BLK_STAT && !off[7];
    assign st_out    = off[6:4];
    assign st_k      = off[3:2];

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [31:0] m);
        merge = (old & ~m) | (d & m);
    endfunction

    // ==========================================================
    // read mux; unmapped reads return zero
    logic [31:0] rd_next;
    always_comb begin
        rd_next = 32'h0000_0000;
        if (adr_i == SUMMARY_ADDR) begin
            rd_next = cb.summary;                                    // see R4 R5
        end else if (is_en) begin
            rd_next = en_reg[en_out][en_idx];
        end else if (is_stat) begin
            rd_next = stat_w[st_out][st_k];                          // see R19
        end else if (hit_local && off == OFF_CTRL) begin
            rd_next = {24'h000000, ctrl_reg};
        end else if (hit_local && (off == OFF_SOFT_SET || off == OFF_SOFT_CLR)) begin
            rd_next = {24'h000000, soft_reg};
        end else if (hit_local && (off == OFF_PMU_SET || off == OFF_PMU_CLR)) begin
            rd_next = {24'h000000, pmu_reg};
        end else if (hit_local && off == OFF_LROUTE) begin
            rd_next = {28'h0000000, lroute_reg};
        end else if (hit_local && off == OFF_RAW0) begin
            rd_next = raw_w[0];
        end else if (hit_local && off == OFF_RAW1) begin
            rd_next = raw_w[1];
        end else if (hit_local && off == OFF_RAW2) begin
            rd_next = raw_w[2];
        end else if (hit_local && off[11:4] == BLK_TIMER) begin
            rd_next = {24'h000000, timer_ctrl_reg[off[3:2]]};
        end else if (hit_local && off[11:4] == BLK_MBOX) begin
            rd_next = {24'h000000, mbox_ctrl_reg[off[3:2]]};
        end
    end

    // ==========================================================
    // handshake: every access is acked one cycle after it is seen
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= req;
            if (req && !we_i) begin
                dat_reg <= rd_next;
            end
        end
    end

    assign ack_o = ack_reg;
    assign dat_o = dat_reg;

    // ==========================================================
    // plain control registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg   <= CTRL_RESET;                                // see R10
            lroute_reg <= 4'h0;
            for (int c = 0; c < NCORE; c++) begin
                timer_ctrl_reg[c] <= 8'h00;
                mbox_ctrl_reg[c]  <= 8'h00;
            end
        end else if (req && we_i && hit_local) begin
            if (off == OFF_CTRL) begin
                ctrl_reg <= 8'(merge(32'(ctrl_reg), dat_i, bmask));
            end else if (off == OFF_LROUTE) begin
                lroute_reg <= 4'(merge(32'(lroute_reg), dat_i, bmask));
            end else if (off[11:4] == BLK_TIMER) begin
                timer_ctrl_reg[off[3:2]] <= 8'(merge(32'(timer_ctrl_reg[off[3:2]]), dat_i, bmask));
            end else if (off[11:4] == BLK_MBOX) begin
                mbox_ctrl_reg[off[3:2]] <= 8'(merge(32'(mbox_ctrl_reg[off[3:2]]), dat_i, bmask));
            end
        end
    end

    // ==========================================================
    // set/clear pairs: soft flags, monitor mask, per-output enables
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            soft_reg <= '0;
            pmu_reg  <= 8'h00;
        end else if (req && we_i && hit_local) begin
            if (off == OFF_SOFT_SET) begin
                soft_reg <= soft_reg | wbits[NSOFT-1:0];             // see R2 R23
            end else if (off == OFF_SOFT_CLR) begin
                soft_reg <= soft_reg & ~wbits[NSOFT-1:0];            // see R2 R24
            end else if (off == OFF_PMU_SET) begin
                pmu_reg <= pmu_reg | wbits[7:0];                     // see R12 R23
            end else if (off == OFF_PMU_CLR) begin
                pmu_reg <= pmu_reg & ~wbits[7:0];                    // see R12 R24
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int o = 0; o < NOUT; o++) begin
                for (int k = 0; k < 3; k++) begin
                    en_reg[o][k] <= 32'h0000_0000;
                end
            end
        end else if (req && we_i && is_en) begin
            if (en_k < EN_CLR_FIRST) begin
                en_reg[en_out][en_idx] <= en_reg[en_out][en_idx] | wbits;  // see R18 R23
            end else begin
                en_reg[en_out][en_idx] <= en_reg[en_out][en_idx] & ~wbits; // see R18 R24
            end
        end
    end

    // network numbering lives in the net_l2_i bit index; reserved bits still OR in
endmodule // lira_router

// *** sim/lira_core_model.sv ***
// four cores' interrupt inputs, sampled as a core would see them
`timescale 1ns/1ps
module lira_core_model (
    // clock
    input  wire logic       clk_i,
    // fast and normal requests per core
    input  wire logic [3:0] fiq_i,
    input  wire logic [3:0] irq_i,
    // last sampled request levels
    output logic      [7:0] seen_o
);
    // ==========================================================
    // input sampling
    always_ff @(posedge clk_i) begin
        seen_o <= {irq_i, fiq_i};
    end
endmodule // lira_core_model

// *** sim/lira_router_asserts.sv ***
// port assertions of the legacy interrupt router
`timescale 1ns/1ps
module lira_router_asserts
    import lira_pkg::*;
(
    // clock, reset and bus
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [31:0] adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    // interrupt paths
    input wire logic [3:0]  gic_fiq_i,
    input wire logic [3:0]  gic_irq_i,
    input wire logic [3:0]  core_fiq_o,
    input wire logic [3:0]  core_irq_o,
    input wire logic [7:0]  private_periph_input_o
);
    // ==========================================================
    // shadow of soft flags and selector
    logic [7:0] soft_q;
    logic       leg_q;
    wire        tk  = cyc_i && stb_i && !ack_o;
    wire        loc = adr_i[31:12] == LOCAL_BASE_HI;
    wire [7:0]  p   = private_periph_input_o;
    wire        wr  = tk && we_i && loc && sel_i[0];
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            soft_q <= 8'h00;
        end else if (wr && adr_i[11:0] == OFF_SOFT_SET) begin
            soft_q <= soft_q | dat_i[7:0];
        end else if (wr && adr_i[11:0] == OFF_SOFT_CLR) begin
            soft_q <= soft_q & ~dat_i[7:0];
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            leg_q <= 1'b0;
        end else if (wr && adr_i[11:0] == OFF_CTRL) begin
            leg_q <= dat_i[CTRL_LEGACY];
        end
    end
    // ==========================================================
    // properties
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_ACK_LAT: assert property (tk |=> ack_o) else $error("no ack after request");
    AST_ACK_ONE: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
    AST_ACK_IDLE: assert property (!cyc_i |=> !ack_o) else $error("ack without request");
    AST_DAT_HOLD: assert property ($changed(dat_o) |-> ack_o && !$past(we_i))
        else $error("read data moved outside a read");
    AST_SOFT_RD: assert property (ack_o && $past(tk && !we_i && loc && adr_i[11:0] == OFF_SOFT_SET)
        |-> dat_o[7:0] == $past(soft_q)) else $error("soft flags wrong");
    AST_UNMAP_RD: assert property (ack_o && $past(tk && !we_i && !loc && adr_i != SUMMARY_ADDR)
        |-> dat_o == 32'h0) else $error("unmapped read not zero");
    AST_GIC_SEL: assert property (!leg_q && !$past(leg_q) && !$past(rst_i) |-> core_fiq_o == $past(gic_fiq_i)
        && core_irq_o == $past(gic_irq_i)) else $error("generic path not passed");
    AST_LEG_SEL: assert property (leg_q && $past(leg_q) |-> {core_irq_o, core_fiq_o} == {p[7], p[5], p[3], p[1],
        p[6], p[4], p[2], p[0]}) else $error("legacy path not passed");
    COV_WR: cover property (wr);
    COV_LEG: cover property (leg_q && core_irq_o != 4'h0);
    COV_PPI: cover property (private_periph_input_o[7]);
endmodule // lira_router_asserts
bind lira_router lira_router_asserts lira_router_asserts_inst (.*);

// *** sim/legacy_irq_routing_aggregator_tb.sv ***
// self-checking bench for the legacy interrupt router
`timescale 1ns/1ps
module legacy_irq_routing_aggregator_tb;
    import lira_pkg::*;
    // ==========================================================
    // stimulus, outputs and model state
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc, stb, we, ack, lt, be, bq, ns;
    logic [31:0] adr, dat, dat_o, q;
    logic [15:0] tmr, mbx;
    logic [3:0]  pmu, pb, gf, gi, cf, ci;
    logic [7:0]  aux, i2c, private_periph_input, seen;
    logic [63:0] per;
    logic [2:0]  axs;
    logic [4:0]  spi, uart;
    logic [56:0] nl2;
    int          err_count, num_checks, soft_m;
    always #50 clk_i = ~clk_i;
    lira_router lira_router_inst (.clk_i, .rst_i, .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(4'hf), .dat_i(dat), .dat_o(dat_o), .ack_o(ack), .core_timer_i(tmr), .perfmon_i(pmu),
        .mailbox_i(mbx), .local_timer_i(lt), .bus_error_irq_i(be), .bus_quiet_i(bq), .aux_block_i(aux),
        .periph_i(per), .pair_b_i(pb), .auxser_i(axs), .i2c_i(i2c), .spi_i(spi), .uart_i(uart),
        .net_l2_i(nl2), .net_secure_i(ns), .gic_fiq_i(gf), .gic_irq_i(gi), .core_fiq_o(cf),
        .core_irq_o(ci), .private_periph_input_o(private_periph_input));
    lira_core_model lira_core_model_inst (.clk_i, .fiq_i(cf), .irq_i(ci), .seen_o(seen));
    // ==========================================================
    // helpers
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] g, e);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask
    // held until ack sampled
    task automatic wb(input logic w, input logic [31:0] a, d);
        int n;
        @(posedge clk_i);
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
        for (n = 0; ack !== 1'b1; n++) begin
            if (n == 20) begin
                err_count++;
                summarize();
            end
            @(posedge clk_i);
        end
        q = dat_o;
        {cyc, stb} <= 2'b00;
    endtask
    task automatic chk(input logic [31:0] a, e);
        wb(1'b0, a, 32'h0);
        cmp(q, e);
    endtask
    function automatic logic [31:0] la(input logic [11:0] o);
        return {LOCAL_BASE_HI, o};
    endfunction
    function automatic logic [63:0] exp_lines();
        logic [63:0] l;
        l = per | {1'b0, pb[3], 15'h0, pb[2], 21'h0, pb[1], pb[0], 23'h0};
        {l[63], l[58], l[57], l[54], l[53], l[29]} = {ns, |nl2, |uart, |spi, |i2c, |axs};
        return l;
    endfunction
    // ==========================================================
    // main sequence
    initial begin
        logic [63:0] r;
        int o;
        {cyc, stb, we, adr, dat, tmr, mbx, pmu, pb, aux, i2c, axs, spi, per, nl2, uart, ns, be, gf, gi, bq, lt} <= '0;
        void'($urandom(32'h7ba1));
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        r = {$urandom, $urandom};
        {tmr, mbx, pmu, pb, aux, i2c, axs, spi} <= r;
        per <= {$urandom, $urandom};
        r = {$urandom, $urandom};
        {nl2, uart, ns, be} <= r;
        @(posedge clk_i);
        r = exp_lines();
        chk(la(OFF_RAW0), r[31:0]);
        chk(la(OFF_RAW1), r[63:32]);
        chk(SUMMARY_ADDR, {3'h0, spi, 3'h0, uart[3:1], uart[4], uart[0], i2c, 8'h00});
        repeat (4) begin
            r = {$urandom, $urandom};
            wb(1'b1, la(OFF_SOFT_SET), r[31:0]);
            soft_m |= r[7:0];
            wb(1'b1, la(OFF_SOFT_CLR), r[63:32]);
            soft_m &= ~r[39:32];
            chk(la(OFF_SOFT_SET), soft_m);
            chk(la(OFF_RAW2), {16'h0, soft_m[7:0], aux});
        end
        wb(1'b1, 32'h0000_1000, r[31:0]);
        chk(32'h0000_1000, 32'h0);
        {tmr, mbx, pmu, pb, aux, i2c, axs, spi, per, nl2, uart, ns, be} <= '0;
        {gf, gi} <= r[7:0];
        repeat (3) @(posedge clk_i);
        cmp(seen, {gi, gf});
        wb(1'b1, la(OFF_CTRL), 32'h1);
        for (o = 0; o < 8; o++) begin
            wb(1'b1, la(OFF_LROUTE), 32'h8 | o);
            lt <= 1'b1;
            repeat (3) @(posedge clk_i);
            cmp(private_periph_input, 8'h1 << o);
            cmp(seen, 8'h1 << ((o % 2) * 4 + o / 2));
            lt <= 1'b0;
        end
        uart <= 5'h10;
        wb(1'b1, la(12'h1e4), 32'h0200_0000);
        chk(la(12'h1e4), 32'h0200_0000);
        chk(la(12'h274), 32'h0200_0000);
        chk(la(12'h278), 32'h0200_0000);
        chk(la(12'h27c), 32'h0000_0100);
        cmp(private_periph_input, 8'h80);
        wb(1'b1, la(12'h1f0), 32'h0200_0000);
        repeat (2) @(posedge clk_i);
        cmp(private_periph_input, 8'h00);
        summarize();
    end
endmodule // legacy_irq_routing_aggregator_tb
